//--- src/psa_consts.svh
// Register offsets, field positions, reset values and sequence counts
`ifndef PSA_CONSTS_SVH
`define PSA_CONSTS_SVH

`define PSA_OFS_STATUS 8'h00
`define PSA_OFS_CMD 8'h04
`define PSA_OFS_ACC 8'h08
`define PSA_OFS_PROD 8'h0C
`define PSA_OFS_MCAND 8'h10
`define PSA_OFS_MADDR 8'h14
`define PSA_OFS_MDATA 8'h18

`define PSA_ST_MODE_LSB 0
`define PSA_ST_SAT_BIT 2
`define PSA_ST_OVF_BIT 3
`define PSA_ST_C_BIT 4
`define PSA_ST_BUSY_BIT 5

`define PSA_CMD_OP_LSB 0
`define PSA_CMD_K_LSB 2
`define PSA_CMD_DMA_LSB 4
`define PSA_OP_SET_SHIFT 2'h1
`define PSA_OP_SQ_ACC 2'h2

`define PSA_MODE_RESET 2'h0
`define PSA_SAT_POS 32'h7FFFFFFF
`define PSA_SAT_NEG 32'h80000000
`define PSA_RSHIFT 6
`define PSA_SQ_ACC_CYCLES 3

`endif

//--- src/psa_pkg.sv
// Types shared by the product shift and square-accumulate datapath
package psa_pkg;

  typedef enum logic [1:0] {
    PSA_SHIFT_NONE = 2'h0,
    PSA_SHIFT_LEFT1 = 2'h1,
    PSA_SHIFT_LEFT4 = 2'h2,
    PSA_SHIFT_RIGHT6 = 2'h3
  } psa_shift_mode_t;

  // Gray order along idle -> accumulate -> load -> square -> idle
  typedef enum logic [1:0] {
    PSA_IDLE = 2'h0,
    PSA_ACCUM = 2'h1,
    PSA_LOAD = 2'h3,
    PSA_SQUARE = 2'h2
  } psa_state_t;

  typedef struct packed {
    psa_state_t state;
    psa_shift_mode_t product_shift_mode;
    logic overflow_saturation_mode;
    logic overflow_flag;
    logic carry;
    logic [31:0] acc;
    logic [31:0] prod;
    logic [15:0] mcand;
    logic [6:0] dma;
    logic [6:0] maddr;
    logic [31:0] prdata;
  } psa_regs_t;

endpackage : psa_pkg

//--- src/psa_product_shifter.sv
// Product register output shifter steered by the shift mode
`timescale 1ns/100ps
`default_nettype none
`include "psa_consts.svh"

module psa_product_shifter
  import psa_pkg::*;
(
  input wire logic [31:0] prod,
  input wire psa_shift_mode_t mode,
  output logic [31:0] shifted
);

  always_comb begin
    case (mode)
      PSA_SHIFT_LEFT1: shifted = {prod[30:0], 1'h0};
      PSA_SHIFT_LEFT4: shifted = {prod[27:0], 4'h0};
      PSA_SHIFT_RIGHT6: shifted = $signed(prod) >>> `PSA_RSHIFT;
      default: shifted = prod;
    endcase
  end

endmodule : psa_product_shifter
`default_nettype wire

//--- src/psa_data_mem.sv
// Small data memory with registered read port
`timescale 1ns/100ps
`default_nettype none

module psa_data_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] rdata
);

  if (DEPTH < 2 || DEPTH > (1 << AW)) begin : g_bad_depth
    $error("psa_data_mem: DEPTH does not fit the address width");
  end

  logic [WIDTH-1:0] mem [DEPTH];

  // Array has no reset so it maps onto plain RAM
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else begin
      rdata <= mem[addr];
    end
  end

endmodule : psa_data_mem
`default_nettype wire

//--- src/psa_core.sv
// Product shift mode and square-accumulate datapath with an APB register slave
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "psa_consts.svh"

// How it works
// - A shift-mode command issued while idle copies its two-bit constant into the mode field, and a status write also loads it.
// - Mode right-six shifts the product right six places with sign extension.
// - The left modes shift the product left and fill the vacated low bits with zeros.
// - A square-accumulate first adds the shifted product into the accumulator.
// - It then loads the addressed memory word into the multiplicand and writes its square to the product.
// - That addition updates overflow and carry, and saturates on overflow when saturation mode is on.
module psa_core
  import psa_pkg::*;
#(
  parameter int MEM_DEPTH = 128
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic busy
);

  if (MEM_DEPTH < 2 || MEM_DEPTH > 128) begin : g_bad_depth
    $error("psa_core: MEM_DEPTH must lie within the 7-bit operand address range");
  end

  psa_regs_t r_reg;
  psa_regs_t r_next;
  logic [31:0] shifted;
  logic [15:0] mem_rdata;
  logic [6:0] mem_addr;
  logic mem_we;
  logic [32:0] sum33;
  logic [31:0] sum;
  logic ovf;
  logic wr_acc;
  logic rd_setup;
  logic sel_ok;
  logic cmd_refused;
  logic [1:0] cmd_op;
  logic signed [31:0] mcand_ext;
  logic signed [31:0] rdata_ext;

  // Register index of an address, 7 means unmapped
  function automatic logic [2:0] reg_index(input logic [7:0] a);
    if (a == `PSA_OFS_STATUS) begin
      reg_index = 3'h0;
    end else if (a == `PSA_OFS_CMD) begin
      reg_index = 3'h1;
    end else if (a == `PSA_OFS_ACC) begin
      reg_index = 3'h2;
    end else if (a == `PSA_OFS_PROD) begin
      reg_index = 3'h3;
    end else if (a == `PSA_OFS_MCAND) begin
      reg_index = 3'h4;
    end else if (a == `PSA_OFS_MADDR) begin
      reg_index = 3'h5;
    end else if (a == `PSA_OFS_MDATA) begin
      reg_index = 3'h6;
    end else begin
      reg_index = 3'h7;
    end
  endfunction : reg_index

  psa_product_shifter u_shifter (
    .prod(r_reg.prod),
    .mode(r_reg.product_shift_mode),
    .shifted(shifted)
  );

  psa_data_mem #(
    .WIDTH(16),
    .DEPTH(MEM_DEPTH),
    .AW(7)
  ) u_mem (
    .clk(pclk),
    .rst_n(presetn),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(pwdata[15:0]),
    .rdata(mem_rdata)
  );

  assign busy = (r_reg.state != PSA_IDLE);
  assign pready = 1'h1;
  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign cmd_op = pwdata[`PSA_CMD_OP_LSB +: 2];
  // Widen before multiplying, a 16-bit product would lose the upper half of the square
  assign mcand_ext = {{16{r_reg.mcand[15]}}, r_reg.mcand};
  assign rdata_ext = {{16{mem_rdata[15]}}, mem_rdata};

  // Memory and commands are refused while a square-accumulate runs,
  // since the sequence owns the memory port and the product register
  always_comb begin
    sel_ok = 1'h1;
    cmd_refused = 1'h0;
    if (reg_index(paddr) == 3'h7) begin
      sel_ok = 1'h0;
    end else if (busy && (reg_index(paddr) == 3'h6 || reg_index(paddr) == 3'h1)) begin
      cmd_refused = 1'h1;
    end else if (busy && pwrite && (reg_index(paddr) == 3'h2 || reg_index(paddr) == 3'h3)) begin
      cmd_refused = 1'h1;
    end
  end

  assign pslverr = psel && penable && (!sel_ok || cmd_refused);
  assign mem_addr = busy ? r_reg.dma : r_reg.maddr;
  assign mem_we = wr_acc && sel_ok && !cmd_refused && reg_index(paddr) == 3'h6;

  // Accumulate adder with carry out of bit 31
  assign sum33 = {1'h0, r_reg.acc} + {1'h0, shifted};
  assign ovf = (r_reg.acc[31] == shifted[31]) && (sum33[31] != r_reg.acc[31]);
  always_comb begin
    sum = sum33[31:0];
    if (ovf && r_reg.overflow_saturation_mode) begin
      sum = r_reg.acc[31] ? `PSA_SAT_NEG : `PSA_SAT_POS;
    end
  end

  always_comb begin
    r_next = r_reg;
    // Read data is captured in the setup phase so the access phase answers at once
    if (rd_setup) begin
      r_next.prdata = 32'h0;
      case (reg_index(paddr))
        3'h0: begin
          r_next.prdata[`PSA_ST_MODE_LSB +: 2] = r_reg.product_shift_mode;
          r_next.prdata[`PSA_ST_SAT_BIT] = r_reg.overflow_saturation_mode;
          r_next.prdata[`PSA_ST_OVF_BIT] = r_reg.overflow_flag;
          r_next.prdata[`PSA_ST_C_BIT] = r_reg.carry;
          r_next.prdata[`PSA_ST_BUSY_BIT] = busy;
        end
        3'h2: r_next.prdata = r_reg.acc;
        3'h3: r_next.prdata = r_reg.prod;
        3'h4: r_next.prdata = {16'h0, r_reg.mcand};
        3'h5: r_next.prdata = {25'h0, r_reg.maddr};
        3'h6: r_next.prdata = {16'h0, mem_rdata};
        default: r_next.prdata = 32'h0;
      endcase
    end
    if (wr_acc && sel_ok && !cmd_refused) begin
      case (reg_index(paddr))
        3'h0: begin
          r_next.product_shift_mode = psa_shift_mode_t'(pwdata[`PSA_ST_MODE_LSB +: 2]);
          r_next.overflow_saturation_mode = pwdata[`PSA_ST_SAT_BIT];
          if (pwdata[`PSA_ST_OVF_BIT]) begin
            r_next.overflow_flag = 1'h0;
          end
        end
        3'h1: begin
          if (cmd_op == `PSA_OP_SET_SHIFT) begin
            r_next.product_shift_mode = psa_shift_mode_t'(pwdata[`PSA_CMD_K_LSB +: 2]);
          end else if (cmd_op == `PSA_OP_SQ_ACC) begin
            r_next.dma = pwdata[`PSA_CMD_DMA_LSB +: 7];
            r_next.state = PSA_ACCUM;
          end
        end
        3'h2: r_next.acc = pwdata;
        3'h3: r_next.prod = pwdata;
        3'h5: r_next.maddr = pwdata[6:0];
        default: r_next.maddr = r_reg.maddr;
      endcase
    end
    case (r_reg.state)
      PSA_ACCUM: begin
        r_next.acc = sum;
        r_next.carry = sum33[32];
        if (ovf) begin
          r_next.overflow_flag = 1'h1;
        end
        r_next.state = PSA_LOAD;
      end
      PSA_LOAD: begin
        r_next.mcand = mem_rdata;
        r_next.state = PSA_SQUARE;
      end
      PSA_SQUARE: begin
        r_next.prod = mcand_ext * mcand_ext;
        r_next.state = PSA_IDLE;
      end
      default: r_next.state = r_next.state;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '{state: PSA_IDLE, product_shift_mode: PSA_SHIFT_NONE, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata = r_reg.prdata;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_set_mode_load: assert property (
    wr_acc && paddr == `PSA_OFS_CMD && !busy && cmd_op == `PSA_OP_SET_SHIFT
    |=> r_reg.product_shift_mode == $past(pwdata[`PSA_CMD_K_LSB +: 2]))
    else $error("shift mode not loaded by set command");

  a_status_mode_load: assert property (
    wr_acc && paddr == `PSA_OFS_STATUS
    |=> r_reg.product_shift_mode == $past(pwdata[`PSA_ST_MODE_LSB +: 2]))
    else $error("shift mode not loaded by status write");

  a_right_six_sign: assert property (
    r_reg.product_shift_mode == PSA_SHIFT_RIGHT6
    |-> shifted[25:0] == r_reg.prod[31:6] && shifted[31:26] == {6{r_reg.prod[31]}})
    else $error("right shift by six wrong");

  a_left_zero_fill: assert property (
    r_reg.product_shift_mode == PSA_SHIFT_LEFT4 |-> shifted == (r_reg.prod << 4))
    else $error("left shift by four wrong");

  a_mode_encoding: assert property (
    (r_reg.product_shift_mode == PSA_SHIFT_NONE |-> shifted == r_reg.prod) and
    (r_reg.product_shift_mode == PSA_SHIFT_LEFT1 |-> shifted == {r_reg.prod[30:0], 1'h0}))
    else $error("shift mode encoding wrong");

  a_accum_add: assert property (
    r_reg.state == PSA_ACCUM && !r_reg.overflow_saturation_mode
    |=> r_reg.acc == $past(r_reg.acc + shifted))
    else $error("accumulate did not add shifted product");

  a_square_chain: assert property (
    r_reg.state == PSA_LOAD ##1 r_reg.state == PSA_SQUARE
    |=> r_reg.mcand == $past(mem_rdata, 2)
        && r_reg.prod == $past(rdata_ext, 2) * $past(rdata_ext, 2))
    else $error("square of loaded word not written to product");

  a_square_accumulate_instr_length: assert property (
    $rose(busy) |-> busy [*3] ##1 !busy)
    else $error("square-accumulate sequence length wrong");

  a_ovf_saturate: assert property (
    r_reg.state == PSA_ACCUM && ovf && r_reg.overflow_saturation_mode
    |=> r_reg.overflow_flag && (r_reg.acc == `PSA_SAT_POS || r_reg.acc == `PSA_SAT_NEG))
    else $error("overflow saturation or flag wrong");

  a_carry_update: assert property (
    r_reg.state == PSA_ACCUM |=> r_reg.carry == $past(sum33[32]))
    else $error("carry not updated by accumulate");

endmodule : psa_core
`default_nettype wire

//--- verification/product_shift_square_accumulate_test.sv
// Self-checking bench for the product shift and square-accumulate datapath
`timescale 1ns/100ps
`default_nettype none
`include "psa_consts.svh"

module product_shift_square_accumulate_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic busy;
  int n_fail = 0;
  int total_checks = 0;
  int busy_cnt = 0;
  int seed = 32'hADCD678F;
  // Each entry is {pslverr, read data}; writes expect zero data
  logic [32:0] exp_q[$];

  always #25 pclk = ~pclk;

  psa_core #(.MEM_DEPTH(128)) DUT (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .busy(busy)
  );

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      if (exp_q.size() == 0) n_fail++;
      else check({pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front());
    end
  end

  // Busy must stand for the three sequence cycles after an accepted command
  always @(posedge pclk) begin
    if (presetn) begin
      check({32'h0, busy}, {32'h0, busy_cnt != 0});
      if (busy_cnt != 0) busy_cnt--;
      else if (psel && penable && pwrite && paddr == `PSA_OFS_CMD &&
               pwdata[`PSA_CMD_OP_LSB +: 2] == `PSA_OP_SQ_ACC) busy_cnt = `PSA_SQ_ACC_CYCLES;
    end
  end

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] exp);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    exp_q.push_back(exp);
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_fail++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [31:0] shift_exp(input logic [31:0] p, input logic [1:0] m);
    case (m)
      2'h0: return p;
      2'h1: return p << 1;
      2'h2: return p << 4;
      default: return $signed(p) >>> `PSA_RSHIFT;
    endcase
  endfunction : shift_exp

  initial begin
    logic [31:0] acc, prod, sh, res;
    logic signed [31:0] sq;
    logic [32:0] sum;
    logic [15:0] w;
    logic [6:0] ad;
    logic [1:0] mode;
    logic sat, ovf;
    int n;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `PSA_OFS_STATUS, 32'h0, 33'h0);
    apb(0, 8'h1C, 32'h0, {1'b1, 32'h0});
    for (int k = 0; k < 4; k++) begin
      apb(1, `PSA_OFS_CMD, {28'h0, 2'(k), `PSA_OP_SET_SHIFT}, 33'h0);
      apb(0, `PSA_OFS_STATUS, 32'h0, {31'h0, 2'(k)});
    end
    for (int i = 0; i < 10; i++) begin
      mode = 2'(i);
      sat = (i >= 4);
      acc = $random(seed);
      prod = $random(seed);
      w = 16'($random(seed));
      ad = 7'($random(seed));
      // Forced overflow in both directions so saturation is really exercised
      if (i == 8) begin
        acc = 32'h7FFF0000;
        prod = 32'h7FFF0000;
      end
      if (i == 9) begin
        acc = 32'h80010000;
        prod = 32'hC0000000;
      end
      apb(1, `PSA_OFS_STATUS, {28'h0, 1'b1, sat, mode}, 33'h0);
      apb(1, `PSA_OFS_ACC, acc, 33'h0);
      apb(1, `PSA_OFS_PROD, prod, 33'h0);
      apb(1, `PSA_OFS_MADDR, {25'h0, ad}, 33'h0);
      apb(1, `PSA_OFS_MDATA, {16'h0, w}, 33'h0);
      apb(0, `PSA_OFS_MDATA, 32'h0, {17'h0, w});
      apb(0, `PSA_OFS_MADDR, 32'h0, {26'h0, ad});
      apb(1, `PSA_OFS_CMD, {21'h0, ad, 2'h0, `PSA_OP_SQ_ACC}, 33'h0);
      apb(1, `PSA_OFS_ACC, 32'h0, {1'b1, 32'h0});
      n = 0;
      while (busy !== 1'b0 && n < 20) begin
        @(posedge pclk);
        n++;
      end
      if (n >= 20) n_fail++;
      sh = shift_exp(prod, mode);
      sum = {1'b0, acc} + {1'b0, sh};
      ovf = (acc[31] == sh[31]) && (sum[31] != acc[31]);
      res = (sat && ovf) ? (acc[31] ? `PSA_SAT_NEG : `PSA_SAT_POS) : sum[31:0];
      sq = $signed(w) * $signed(w);
      apb(0, `PSA_OFS_ACC, 32'h0, {1'b0, res});
      apb(0, `PSA_OFS_PROD, 32'h0, {1'b0, sq});
      apb(0, `PSA_OFS_MCAND, 32'h0, {17'h0, w});
      apb(0, `PSA_OFS_STATUS, 32'h0, {28'h0, sum[32], ovf, sat, mode});
    end
    repeat (3) @(posedge pclk);
    if (exp_q.size() != 0) n_fail++;
    finish_test();
  end

  initial begin
    #(50 * 5000);
    n_fail++;
    finish_test();
  end
endmodule : product_shift_square_accumulate_test
`default_nettype wire
